/* ircc_carrier.sv */
// carrier generator: high and low phases counted in selected ticks
`timescale 1ns/1ps
`default_nettype none
module ircc_carrier #(
  parameter int unsigned LEN_W = 6
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [LEN_W-1:0] high_len,
  input  wire logic [LEN_W-1:0] low_len,
  output logic                  carrier
);

  ircc_pkg::ircc_phase_type phase;
  ircc_pkg::ircc_phase_type next_phase;
  logic [LEN_W-1:0]         count;
  logic [LEN_W-1:0]         next_count;
  logic [LEN_W-1:0]         limit;

  // ==========================================================
  // phase sequencing
  always_comb begin
    next_phase = phase;
    next_count = count;
    limit      = (phase == ircc_pkg::CAR_HIGH) ? high_len : low_len;
    if (!run) begin
      next_phase = ircc_pkg::CAR_HIGH;
      next_count = '0;
    end else if (tick) begin
      if (count == limit) begin
        next_count = '0;
        case (phase)
          ircc_pkg::CAR_HIGH: next_phase = ircc_pkg::CAR_LOW;
          default:            next_phase = ircc_pkg::CAR_HIGH;
        endcase
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= ircc_pkg::CAR_HIGH;
      count <= '0;
    end else if (ce) begin
      phase <= next_phase;
      count <= next_count;
    end
  end

  assign carrier = phase[0];

endmodule // ircc_carrier
`default_nettype wire

/* ircc_edge.sv */
// receive pin synchroniser, noise filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module ircc_edge (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic run,
  input  wire logic tick,
  input  wire logic rx_pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic sync1;
  logic sync2;
  logic hist;
  logic next_hist;
  logic next_level;
  logic next_rise;
  logic next_fall;

  // ==========================================================
  // filter and detection
  always_comb begin
    next_hist  = hist;
    next_level = level;
    next_rise  = 1'b0;
    next_fall  = 1'b0;
    if (!run) begin
      next_hist  = sync2;
      next_level = sync2;
    end else if (tick) begin
      next_hist = sync2;
      if (hist == sync2 && sync2 != level) begin
        next_level = sync2;
        next_rise  = sync2;
        next_fall  = !sync2;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      hist  <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else if (ce) begin
      sync1 <= rx_pin;
      sync2 <= sync1;
      hist  <= next_hist;
      level <= next_level;
      rise  <= next_rise;
      fall  <= next_fall;
    end
  end

endmodule // ircc_edge
`default_nettype wire

/* ircc_ir_model.sv */
// infrared receiver and emitter driver model at the unit's pins
`timescale 1ns/1ps
`default_nettype none
module ircc_ir_model (
  input  wire logic aclk,
  input  wire logic led_drive,
  output var logic  rx_level
);
  int unsigned led_cycles;
  initial begin
    rx_level = 1'h0;
    led_cycles = 0;
  end
  // ==========
  // emitter lit time
  always @(posedge aclk) begin
    if (led_drive) begin
      led_cycles <= led_cycles + 1;
    end
  end
  // ==========
  // receiver output level, held n cycles
  task automatic emit(input logic lvl, input int unsigned n);
    @(posedge aclk);
    rx_level <= lvl;
    repeat (n) @(posedge aclk);
  endtask
endmodule // ircc_ir_model
`default_nettype wire

/* ircc_pkg.sv */
// constants and types shared by the infrared remote carrier counter
package ircc_pkg;

  // register indices; byte address is index times four
  localparam logic [15:0] IDX_CFG  = 16'h5340;
  localparam logic [15:0] IDX_PSC  = 16'h5341;
  localparam logic [15:0] IDX_CARH = 16'h5342;
  localparam logic [15:0] IDX_CARL = 16'h5343;
  localparam logic [15:0] IDX_ST   = 16'h5344;
  localparam logic [15:0] IDX_LCNT = 16'h5345;
  localparam logic [15:0] IDX_IMSK = 16'h5346;
  localparam logic [15:0] IDX_IFLG = 16'h5347;
  localparam int unsigned IDX_SHIFT = 2;

  // decoded register selectors
  localparam logic [3:0] SEL_CFG  = 4'h0;
  localparam logic [3:0] SEL_PSC  = 4'h1;
  localparam logic [3:0] SEL_CARH = 4'h2;
  localparam logic [3:0] SEL_CARL = 4'h3;
  localparam logic [3:0] SEL_ST   = 4'h4;
  localparam logic [3:0] SEL_LCNT = 4'h5;
  localparam logic [3:0] SEL_IMSK = 4'h6;
  localparam logic [3:0] SEL_IFLG = 4'h7;
  localparam logic [3:0] SEL_NONE = 4'hF;

  // field positions and widths
  localparam int unsigned CFG_EN_BIT   = 0;
  localparam int unsigned CFG_MODE_BIT = 1;
  localparam int unsigned ST_DATA_BIT  = 0;
  localparam int unsigned PSC_LEN_LSB  = 0;
  localparam int unsigned PSC_CAR_LSB  = 4;
  localparam int unsigned CLK_SEL_W    = 4;
  localparam int unsigned CAR_LEN_W    = 6;
  localparam int unsigned CNT_W        = 8;
  localparam int unsigned PRESC_W      = 14;
  localparam int unsigned FLG_W        = 3;
  localparam int unsigned FLG_UNDER    = 0;
  localparam int unsigned FLG_RISE     = 1;
  localparam int unsigned FLG_FALL     = 2;

  // reset values and codes
  localparam logic [7:0] PSC_RESET     = 8'h00;
  localparam logic [5:0] CAR_LEN_RESET = 6'h00;
  localparam logic [3:0] CLK_RESERVED  = 4'hF;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    CAR_HIGH = 2'b01,
    CAR_LOW  = 2'b10
  } ircc_phase_type;

endpackage

/* ircc_sva.sv */
// assertion checker for the infrared remote unit ports
`timescale 1ns/1ps
`default_nettype none
module ircc_sva #(
  parameter int unsigned CNT_W   = ircc_pkg::CNT_W,
  parameter int unsigned PRESC_W = ircc_pkg::PRESC_W
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        ir_transmit_pin,
  input wire logic        irq
);
  // ==========
  // shadow of control bits
  logic       en;
  logic       md;
  logic       dat;
  logic [2:0] msk;
  logic       aw_p;
  logic       w_p;
  logic       w_s;
  logic [31:0] aw_a;
  logic [31:0] w_d;
  logic       wr_commit;
  // commit in the cycle the unit updates its register
  assign wr_commit = aw_p && w_p && !s_axi_bvalid && ce;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en   <= 1'h0;
      md   <= 1'h0;
      dat  <= 1'h0;
      msk  <= 3'h0;
      aw_p <= 1'h0;
      w_p  <= 1'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_p <= 1'h1;
        aw_a <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_p <= 1'h1;
        w_d <= s_axi_wdata;
        w_s <= s_axi_wstrb[0];
      end
      if (wr_commit) begin
        aw_p <= 1'h0;
        w_p  <= 1'h0;
      end
      if (wr_commit && w_s) begin
        if (aw_a == {14'h0000, ircc_pkg::IDX_CFG, 2'h0}) begin
          en <= w_d[0];
          md <= w_d[1];
        end
        if (aw_a == {14'h0000, ircc_pkg::IDX_ST, 2'h0}) begin
          dat <= w_d[0];
        end
        if (aw_a == {14'h0000, ircc_pkg::IDX_IMSK, 2'h0}) begin
          msk <= w_d[2:0];
        end
      end
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_answer: assert property (wr_commit |=> s_axi_bvalid)
    else $error("write response missing");
  chk_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  chk_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  chk_unmapped: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[31:5] != 27'h0000A68 |=> s_axi_rresp == ircc_pkg::RESP_SLVERR
    && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_tx_gate: assert property (
    ir_transmit_pin |-> $past(en && !md && dat))
    else $error("transmit pin high without data");
  chk_irq_mask: assert property (irq |-> msk != 3'h0)
    else $error("interrupt with all causes masked");
  chk_reset_quiet: assert property (@(posedge aclk) disable iff (1'h0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !ir_transmit_pin)
    else $error("outputs active after reset");
endmodule // ircc_sva
bind ircc_top ircc_sva #(.CNT_W(CNT_W), .PRESC_W(PRESC_W)) ircc_sva_inst (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ir_transmit_pin(ir_transmit_pin), .irq(irq)
);
`default_nettype wire

/* ircc_tb.sv */
// self-checking bench for the infrared remote unit
`timescale 1ns/1ps
`default_nettype none
module ircc_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx, tx, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          failures, n_tests;

  ircc_top ircc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(1'h1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ir_receive_pin(rx),
    .ir_transmit_pin(tx), .irq(irq)
  );
  ircc_ir_model ircc_ir_model_inst (.aclk(aclk), .led_drive(tx), .rx_level(rx));

  initial aclk = 1'h0;
  always #50 aclk = ~aclk;

  // ==========
  // checks and closing
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [1:0] resp_of(input logic [15:0] idx);
    return (idx[15:3] == 13'h0A68) ? ircc_pkg::RESP_OKAY : ircc_pkg::RESP_SLVERR;
  endfunction

  // ==========
  // bus master
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= {14'h0000, idx, 2'h0};
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    cmp({30'h0, bresp}, {30'h0, resp_of(idx)});
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] d);
    @(posedge aclk);
    araddr  <= {14'h0000, idx, 2'h0};
    arvalid <= 1'h1;
    rready  <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    rready <= 1'h0;
    cmp({30'h0, rresp}, {30'h0, resp_of(idx)});
  endtask
  task automatic chk_rd(input logic [15:0] idx, input logic [31:0] e);
    logic [31:0] d;
    rd(idx, d);
    cmp(d, e);
  endtask

  // ==========
  // pin observation
  task automatic meas(output int unsigned hi, output int unsigned lo);
    hi = 0;
    lo = 0;
    do @(posedge aclk); while (tx);
    do @(posedge aclk); while (!tx);
    while (tx) begin
      hi++;
      @(posedge aclk);
    end
    while (!tx) begin
      lo++;
      @(posedge aclk);
    end
  endtask
  task automatic quiet();
    int unsigned n0;
    @(posedge aclk);
    n0 = ircc_ir_model_inst.led_cycles;
    repeat (40) @(posedge aclk);
    cmp(ircc_ir_model_inst.led_cycles - n0, 32'h0);
  endtask

  // ==========
  // test sequence
  initial begin
    int unsigned hi, lo, n;
    logic [31:0] v;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      chk_rd(ircc_pkg::IDX_CFG + 16'(i), 32'h0);
    end
    chk_rd(16'h5348, 32'h0);
    wr(16'h5348, 32'h000000FF);
    wr(ircc_pkg::IDX_PSC, 32'h000001E7);
    chk_rd(ircc_pkg::IDX_PSC, 32'h000000E7);
    wstrb <= 4'h0;
    wr(ircc_pkg::IDX_PSC, 32'h00000033);
    wstrb <= 4'hF;
    chk_rd(ircc_pkg::IDX_PSC, 32'h000000E7);
    wr(ircc_pkg::IDX_CARH, 32'h2);
    wr(ircc_pkg::IDX_CARL, 32'h1);
    wr(ircc_pkg::IDX_ST, 32'h1);
    for (int c = 0; c < 3; c += 2) begin
      wr(ircc_pkg::IDX_CFG, 32'h0);
      wr(ircc_pkg::IDX_PSC, 32'(c) << 4);
      wr(ircc_pkg::IDX_CFG, 32'h1);
      meas(hi, lo);
      cmp(hi, 32'(3 << c));
      cmp(lo, 32'(2 << c));
    end
    wr(ircc_pkg::IDX_ST, 32'h0);
    quiet();
    wr(ircc_pkg::IDX_ST, 32'h1);
    wr(ircc_pkg::IDX_CFG, 32'h3);
    quiet();
    wr(ircc_pkg::IDX_IMSK, 32'h1);
    wr(ircc_pkg::IDX_PSC, 32'h4);
    wr(ircc_pkg::IDX_LCNT, 32'hFF);
    repeat (160) @(posedge aclk);
    rd(ircc_pkg::IDX_LCNT, v);
    cmp(32'(v >= 32'hF4 && v <= 32'hF6), 32'h1);
    wr(ircc_pkg::IDX_LCNT, 32'h3);
    n = 0;
    while (!irq && n < 100) begin
      @(posedge aclk);
      n++;
    end
    cmp(32'(n >= 30 && n <= 52), 32'h1);
    repeat (40) @(posedge aclk);
    chk_rd(ircc_pkg::IDX_LCNT, 32'h0);
    chk_rd(ircc_pkg::IDX_IFLG, 32'h1);
    wr(ircc_pkg::IDX_LCNT, 32'h1);
    repeat (40) @(posedge aclk);
    cmp({31'h0, irq}, 32'h1);
    wr(ircc_pkg::IDX_IFLG, 32'h1);
    repeat (3) @(posedge aclk);
    cmp({31'h0, irq}, 32'h0);
    wr(ircc_pkg::IDX_IMSK, 32'h0);
    wr(ircc_pkg::IDX_LCNT, 32'h1);
    repeat (40) @(posedge aclk);
    chk_rd(ircc_pkg::IDX_IFLG, 32'h0);
    wr(ircc_pkg::IDX_PSC, 32'h0F);
    wr(ircc_pkg::IDX_LCNT, 32'h2);
    repeat (40) @(posedge aclk);
    chk_rd(ircc_pkg::IDX_LCNT, 32'h2);
    wr(ircc_pkg::IDX_IMSK, 32'h6);
    wr(ircc_pkg::IDX_PSC, 32'h20);
    ircc_ir_model_inst.emit(1'h1, 24);
    cmp({31'h0, irq}, 32'h1);
    chk_rd(ircc_pkg::IDX_IFLG, 32'h2);
    chk_rd(ircc_pkg::IDX_ST, 32'h1);
    ircc_ir_model_inst.emit(1'h0, 24);
    chk_rd(ircc_pkg::IDX_IFLG, 32'h4);
    ircc_ir_model_inst.emit(1'h1, 2);
    ircc_ir_model_inst.emit(1'h0, 24);
    chk_rd(ircc_pkg::IDX_IFLG, 32'h0);
    end_sim();
  end

  initial begin
    repeat (10000) @(posedge aclk);
    failures++;
    end_sim();
  end
endmodule // ircc_tb
`default_nettype wire

/* ircc_top.sv */
// infrared remote unit: register slave, clock taps, counter, modulator
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ircc_top #(
  parameter int unsigned CNT_W   = ircc_pkg::CNT_W,
  parameter int unsigned PRESC_W = ircc_pkg::PRESC_W
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ir_receive_pin,
  output logic             ir_transmit_pin,
  output logic             irq
);
  // ==========================================================
  // address decode and clock taps
  function automatic logic [31:0] byte_addr(input logic [15:0] idx);
    return {14'h0000, idx, 2'h0};
  endfunction
  function automatic logic [3:0] decode(input logic [31:0] addr);
    logic [3:0] sel;
    sel = ircc_pkg::SEL_NONE;
    if (addr == byte_addr(ircc_pkg::IDX_CFG)) sel = ircc_pkg::SEL_CFG;
    else if (addr == byte_addr(ircc_pkg::IDX_PSC)) sel = ircc_pkg::SEL_PSC;
    else if (addr == byte_addr(ircc_pkg::IDX_CARH)) sel = ircc_pkg::SEL_CARH;
    else if (addr == byte_addr(ircc_pkg::IDX_CARL)) sel = ircc_pkg::SEL_CARL;
    else if (addr == byte_addr(ircc_pkg::IDX_ST)) sel = ircc_pkg::SEL_ST;
    else if (addr == byte_addr(ircc_pkg::IDX_LCNT)) sel = ircc_pkg::SEL_LCNT;
    else if (addr == byte_addr(ircc_pkg::IDX_IMSK)) sel = ircc_pkg::SEL_IMSK;
    else if (addr == byte_addr(ircc_pkg::IDX_IFLG)) sel = ircc_pkg::SEL_IFLG;
    return sel;
  endfunction
  // tick when the low code bits of the prescaler are all ones; no tick for CLK_RESERVED
  function automatic logic tap_tick(input logic [PRESC_W-1:0] cnt, input logic [3:0] code);
    logic hit;
    hit = (code != ircc_pkg::CLK_RESERVED);
    for (int i = 0; i < PRESC_W; i++) begin
      if (i < int'(code) && !cnt[i]) begin
        hit = 1'b0;
      end
    end
    return hit;
  endfunction
  // ==========================================================
  // state
  logic [31:0]        aw_addr;
  logic               aw_held;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               w_held;
  logic [31:0]        next_aw_addr;
  logic               next_aw_held;
  logic [31:0]        next_w_data;
  logic [3:0]         next_w_strb;
  logic               next_w_held;
  logic               next_bvalid;
  logic [1:0]         next_bresp;
  logic               next_rvalid;
  logic [31:0]        next_rdata;
  logic [1:0]         next_rresp;
  logic               unit_enable_bit;
  logic               direction_mode_bit;
  logic               line_data_bit;
  logic [7:0]         psc_reg;
  logic [5:0]         carrier_high_len;
  logic [5:0]         carrier_low_len;
  logic [CNT_W-1:0]   length_counter_value;
  logic [ircc_pkg::FLG_W-1:0] irq_enable;
  logic [ircc_pkg::FLG_W-1:0] irq_flag;
  logic [PRESC_W-1:0] presc;
  logic               next_enable;
  logic               next_mode;
  logic               next_data;
  logic [7:0]         next_psc;
  logic [5:0]         next_carh;
  logic [5:0]         next_carl;
  logic [CNT_W-1:0]   next_count;
  logic [ircc_pkg::FLG_W-1:0] next_ienable;
  logic [ircc_pkg::FLG_W-1:0] next_iflag;
  logic [ircc_pkg::FLG_W-1:0] events;
  logic               next_tx;
  logic               underflow;
  logic               wr_go;
  logic               rd_go;
  logic [3:0]         wr_sel;
  logic [3:0]         rd_sel;
  logic               carrier_tick;
  logic               length_tick;
  logic               carrier;
  logic               rx_level;
  logic               rx_rise;
  logic               rx_fall;
  logic [3:0]         carrier_clock_sel;
  logic [3:0]         length_clock_sel;
  assign carrier_clock_sel = psc_reg[ircc_pkg::PSC_CAR_LSB +: ircc_pkg::CLK_SEL_W];
  assign length_clock_sel  = psc_reg[ircc_pkg::PSC_LEN_LSB +: ircc_pkg::CLK_SEL_W];
  assign carrier_tick      = tap_tick(presc, carrier_clock_sel);
  assign length_tick       = tap_tick(presc, length_clock_sel);
  // ==========================================================
  // submodules
  ircc_carrier #(
    .LEN_W    (ircc_pkg::CAR_LEN_W)
  ) u_carrier (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .run      (unit_enable_bit),
    .tick     (carrier_tick),
    .high_len (carrier_high_len),
    .low_len  (carrier_low_len),
    .carrier  (carrier)
  );
  ircc_edge u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .run     (unit_enable_bit),
    .tick    (carrier_tick),
    .rx_pin  (ir_receive_pin),
    .level   (rx_level),
    .rise    (rx_rise),
    .fall    (rx_fall)
  );
  // ==========================================================
  // bus handshakes
  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign rd_go  = s_axi_arvalid && s_axi_arready;
  assign wr_sel = decode(aw_addr);
  assign rd_sel = decode(s_axi_araddr);
  always_comb begin
    next_aw_addr = aw_addr;
    next_aw_held = aw_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_w_held  = w_held;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_held = 1'b1;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_sel == ircc_pkg::SEL_NONE) ? ircc_pkg::RESP_SLVERR : ircc_pkg::RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp  = ircc_pkg::RESP_OKAY;
      next_rdata  = '0;
      if (rd_sel == ircc_pkg::SEL_CFG) begin
        next_rdata[ircc_pkg::CFG_EN_BIT]   = unit_enable_bit;
        next_rdata[ircc_pkg::CFG_MODE_BIT] = direction_mode_bit;
      end else if (rd_sel == ircc_pkg::SEL_PSC) begin
        next_rdata[7:0] = psc_reg;
      end else if (rd_sel == ircc_pkg::SEL_CARH) begin
        next_rdata[5:0] = carrier_high_len;
      end else if (rd_sel == ircc_pkg::SEL_CARL) begin
        next_rdata[5:0] = carrier_low_len;
      end else if (rd_sel == ircc_pkg::SEL_ST) begin
        next_rdata[ircc_pkg::ST_DATA_BIT] = direction_mode_bit ? rx_level : line_data_bit;
      end else if (rd_sel == ircc_pkg::SEL_LCNT) begin
        next_rdata[CNT_W-1:0] = length_counter_value;
      end else if (rd_sel == ircc_pkg::SEL_IMSK) begin
        next_rdata[ircc_pkg::FLG_W-1:0] = irq_enable;
      end else if (rd_sel == ircc_pkg::SEL_IFLG) begin
        next_rdata[ircc_pkg::FLG_W-1:0] = irq_flag;
      end else begin
        next_rresp = ircc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr      <= '0;
      aw_held      <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      w_held       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ircc_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ircc_pkg::RESP_OKAY;
    end else if (ce) begin
      aw_addr      <= next_aw_addr;
      aw_held      <= next_aw_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      w_held       <= next_w_held;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end
  // ==========================================================
  // registers, length counter, flags and modulator
  always_comb begin
    next_enable  = unit_enable_bit;
    next_mode    = direction_mode_bit;
    next_data    = line_data_bit;
    next_psc     = psc_reg;
    next_carh    = carrier_high_len;
    next_carl    = carrier_low_len;
    next_count   = length_counter_value;
    next_ienable = irq_enable;
    next_iflag   = irq_flag;
    underflow    = 1'b0;
    // decrement per tick, stop at zero
    if (unit_enable_bit && length_tick && length_counter_value != '0) begin
      next_count = length_counter_value - 1'b1;
      underflow  = (next_count == '0);
    end
    if (wr_go && w_strb[0]) begin
      if (wr_sel == ircc_pkg::SEL_CFG) begin
        next_enable = w_data[ircc_pkg::CFG_EN_BIT];
        next_mode   = w_data[ircc_pkg::CFG_MODE_BIT];
      end else if (wr_sel == ircc_pkg::SEL_PSC) begin
        next_psc = w_data[7:0];
      end else if (wr_sel == ircc_pkg::SEL_CARH) begin
        next_carh = w_data[ircc_pkg::CAR_LEN_W-1:0];
      end else if (wr_sel == ircc_pkg::SEL_CARL) begin
        next_carl = w_data[ircc_pkg::CAR_LEN_W-1:0];
      end else if (wr_sel == ircc_pkg::SEL_ST) begin
        next_data = w_data[ircc_pkg::ST_DATA_BIT];
      end else if (wr_sel == ircc_pkg::SEL_LCNT) begin
        next_count = w_data[CNT_W-1:0];
        underflow  = 1'b0;
      end else if (wr_sel == ircc_pkg::SEL_IMSK) begin
        next_ienable = w_data[ircc_pkg::FLG_W-1:0];
      end else if (wr_sel == ircc_pkg::SEL_IFLG) begin
        next_iflag = next_iflag & ~w_data[ircc_pkg::FLG_W-1:0];
      end
    end
    if (rd_go && rd_sel == ircc_pkg::SEL_IFLG) begin
      next_iflag = '0;
    end
    events = '0;
    events[ircc_pkg::FLG_UNDER] = underflow;
    events[ircc_pkg::FLG_RISE]  = rx_rise;
    events[ircc_pkg::FLG_FALL]  = rx_fall;
    next_iflag = next_iflag | (events & irq_enable);
    next_tx = unit_enable_bit && !direction_mode_bit && line_data_bit && carrier;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_enable_bit      <= 1'b0;
      direction_mode_bit   <= 1'b0;
      line_data_bit        <= 1'b0;
      psc_reg              <= ircc_pkg::PSC_RESET;
      carrier_high_len     <= ircc_pkg::CAR_LEN_RESET;
      carrier_low_len      <= ircc_pkg::CAR_LEN_RESET;
      length_counter_value <= '0;
      irq_enable           <= '0;
      irq_flag             <= '0;
      presc                <= '0;
      ir_transmit_pin      <= 1'b0;
      irq                  <= 1'b0;
    end else if (ce) begin
      unit_enable_bit      <= next_enable;
      direction_mode_bit   <= next_mode;
      line_data_bit        <= next_data;
      psc_reg              <= next_psc;
      carrier_high_len     <= next_carh;
      carrier_low_len      <= next_carl;
      length_counter_value <= next_count;
      irq_enable           <= next_ienable;
      irq_flag             <= next_iflag;
      presc                <= presc + 1'b1;
      ir_transmit_pin      <= next_tx;
      irq                  <= |(next_iflag & next_ienable);
    end
  end
endmodule // ircc_top
`default_nettype wire
